// file: core/nsc_pkg.sv
// Purpose: Constants and types for the network state controller.
// Assumes: One 40 MHz clock; registers reached over a plain port.
// Notes:   Reset values apply at power-on and on the reset commands; ERR_VAL_RST on power-on and 81H only.
package nsc_pkg;

  localparam logic [10:0] NMT_ID      = 11'h000;
  localparam logic [3:0]  NMT_LEN     = 4'h2;
  localparam logic [7:0]  BROADCAST   = 8'h00;
  localparam logic [7:0]  CS_START    = 8'h01;
  localparam logic [7:0]  CS_STOP     = 8'h02;
  localparam logic [7:0]  CS_PREOP    = 8'h80;
  localparam logic [7:0]  CS_RST_NODE = 8'h81;
  localparam logic [7:0]  CS_RST_COMM = 8'h82;

  localparam logic [7:0]  ST_BOOT     = 8'h00;
  localparam logic [7:0]  ST_STOP     = 8'h04;
  localparam logic [7:0]  ST_OPER     = 8'h05;
  localparam logic [7:0]  ST_PREOP    = 8'h7F;

  localparam logic [3:0]  INIT_CYCLES = 4'h3;
  localparam logic [3:0]  MAX_PDO_LEN = 4'h8;
  localparam logic [10:0] RPDO_BASE   = 11'h200;
  localparam logic [10:0] TPDO_BASE   = 11'h180;

  localparam logic [3:0]  A_STATE     = 4'h0;
  localparam logic [3:0]  A_GUARD     = 4'h1;
  localparam logic [3:0]  A_FACTOR    = 4'h2;
  localparam logic [3:0]  A_HB        = 4'h3;
  localparam logic [3:0]  A_RPDO_ID   = 4'h4;
  localparam logic [3:0]  A_TPDO_ID   = 4'h5;
  localparam logic [3:0]  A_MAP_CNT   = 4'h6;
  localparam logic [3:0]  A_ERR       = 4'h7;
  localparam logic [3:0]  A_ERR_LOG   = 4'h8;
  localparam logic [3:0]  A_ERR_VAL   = 4'h9;
  localparam logic [3:0]  A_RX_MAP    = 4'hA;
  localparam logic [3:0]  A_TX_MAP_LO = 4'hB;
  localparam logic [3:0]  A_TX_MAP_HI = 4'hC;

  localparam logic [15:0] GUARD_RST   = 16'h0000;
  localparam logic [7:0]  FACTOR_RST  = 8'h00;
  localparam logic [15:0] HB_RST      = 16'h0000;
  localparam logic [15:0] ERR_VAL_RST = 16'h0000;
  localparam logic [3:0]  RX_CNT_RST  = 4'h2;
  localparam logic [3:0]  TX_CNT_RST  = 4'h3;
  localparam logic [31:0] RX_MAP_RST  = 32'h0000_0021;
  localparam logic [63:0] TX_MAP_RST  = 64'h0000_0000_0003_0201;

  typedef enum logic [3:0] {
    S_INIT  = 4'b0001,
    S_PREOP = 4'b0010,
    S_OPER  = 4'b0100,
    S_STOP  = 4'b1000
  } nsc_state_type;

endpackage

// file: core/nsc_top.sv
// Purpose: Node state controller with service gating and I/O mapping.
// Assumes: Frames arrive already decoded; inputs synchronous to mclk.
// Notes:   The register port stands for the service-data path.
//
// What this block does
// - A state command has identifier zero, two bytes: command, target.
// - Execute commands addressed to our node address or to address zero.
// - Command 01H enters operational, starts process data, activates outputs.
// - Command 02H enters stopped, halts process data, outputs in error state.
// - Command 80H enters pre-operational, halts process data, keeps service.
// - Command 81H resets everything, reruns start-up, ends pre-operational.
// - Command 82H resets communication parameters only, ends pre-operational.
// - After power-on initialise, then enter pre-operational unprompted.
// - Pre-operational: no process data; service access remains available.
// - Operational: process data exchanged and service access still served.
// - Stopped: no process, sync or emergency traffic; service reads still served, writes refused.
// - Stopped: guarding responses and enabled heartbeat keep running.
// - Only a state command frame takes the node out of stopped.
// - Life time is guard time times life factor when both nonzero.
// - A process-data message carries at most eight mapped bytes.
// - Matching receive identifier spreads bytes to objects in mapping order.
// - Three input bytes, two output bytes, eight analog words, four pulses.
// - Service access after boot; process-data access only when operational.
// - Default mapping applied; mapping changes only by service writes.
// - Errors set an error register and enter a separate error log.
// - State byte: 00H boot, 04H stopped, 05H operational, 7FH pre-op.
`timescale 1ns/1ps

module nsc_top
  import nsc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [6:0]  target_node_address,
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic [3:0]  rx_len,
  input  wire logic [63:0] rx_data,
  input  wire logic [23:0] digital_input,
  input  wire logic [127:0] analog_input,
  input  wire logic        tx_trigger,
  input  wire logic        err_event,
  input  wire logic [7:0]  err_class,
  input  wire logic [7:0]  err_code,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             tx_valid,
  output logic [10:0]      tx_id,
  output logic [3:0]       tx_len,
  output logic [63:0]      tx_data,
  output logic             emcy_valid,
  output logic [7:0]       emcy_code,
  output logic             bootup_valid,
  output logic [15:0]      digital_output,
  output logic [63:0]      pulse_output,
  output logic             pdo_enable,
  output logic             sdo_enable,
  output logic             sync_enable,
  output logic             emcy_enable,
  output logic             guard_enable,
  output logic             hb_enable,
  output logic [23:0]      life_time,
  output logic [7:0]       node_state
);
  import nsc_pkg::*;

  typedef struct packed {
    nsc_state_type st;
    logic [3:0]    init_cnt;
    logic          full;
    logic [6:0]    node;
    logic          act;
    logic [15:0]   guard;
    logic [7:0]    factor;
    logic [15:0]   hb;
    logic [10:0]   rpdo_id;
    logic [10:0]   tpdo_id;
    logic [3:0]    rx_cnt;
    logic [3:0]    tx_cnt;
    logic [31:0]   rx_map;
    logic [63:0]   tx_map;
    logic [7:0]    err;
    logic [31:0]   err_log;
    logic [15:0]   err_val;
    logic [15:0]   dout;
    logic [63:0]   pwm;
    logic          tx_v;
    logic [10:0]   tx_id;
    logic [3:0]    tx_len;
    logic [63:0]   tx_data;
    logic          emcy_v;
    logic [7:0]    emcy_code;
    logic          boot_v;
    logic [31:0]   rdata;
  } nsc_regs_type;

  nsc_regs_type r_reg;
  nsc_regs_type r_next;

  logic       nmt_frame;
  logic       addr_ok;
  logic       nmt_hit;
  logic [7:0] cmd;
  logic [7:0] tgt;

  ////////////////////////////////////////////////////////////////////////
  assign cmd       = rx_data[7:0];
  assign tgt       = rx_data[15:8];
  assign nmt_frame = rx_valid && rx_id == NMT_ID
                     && rx_len == NMT_LEN;
  assign addr_ok   = tgt == BROADCAST || tgt == {1'b0, r_reg.node};
  assign nmt_hit   = nmt_frame && addr_ok && r_reg.st != S_INIT;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0] code;
    logic [4:0] sidx;
    logic [7:0] sel;
    logic [7:0] b;
    logic       svc;
    logic [3:0] len;
    code    = 4'h0;
    sidx    = 5'h00;
    sel     = 8'h00;
    b       = 8'h00;
    len     = 4'h0;
    svc     = r_reg.st == S_PREOP || r_reg.st == S_OPER;
    r_next  = r_reg;
    r_next.tx_v   = 1'b0;
    r_next.emcy_v = 1'b0;
    r_next.boot_v = 1'b0;
    r_next.rdata  = 32'h0000_0000;

    unique case (r_reg.st)
      S_INIT: begin
        if (r_reg.init_cnt == 4'h0) begin
          // Communication defaults load here; node and identifiers derive from the strapped address.
          r_next.node    = target_node_address;
          r_next.guard   = GUARD_RST;
          r_next.factor  = FACTOR_RST;
          r_next.hb      = HB_RST;
          r_next.rpdo_id = RPDO_BASE + {4'h0, target_node_address};
          r_next.tpdo_id = TPDO_BASE + {4'h0, target_node_address};
          r_next.rx_cnt  = RX_CNT_RST;
          r_next.tx_cnt  = TX_CNT_RST;
          r_next.rx_map  = RX_MAP_RST;
          r_next.tx_map  = TX_MAP_RST;
          if (r_reg.full) begin
            r_next.err     = 8'h00;
            r_next.err_log = 32'h0000_0000;
            r_next.err_val = ERR_VAL_RST;
            r_next.dout    = 16'h0000;
            r_next.pwm     = 64'h0000_0000_0000_0000;
            r_next.act     = 1'b0;
          end
        end
        if (r_reg.init_cnt == INIT_CYCLES) begin
          r_next.st     = S_PREOP;
          r_next.boot_v = 1'b1;
          r_next.full   = 1'b0;
        end else begin
          r_next.init_cnt = r_reg.init_cnt + 4'h1;
        end
      end
      S_PREOP, S_OPER, S_STOP: begin
        // Leaving stopped needs a command frame; nothing else moves st.
        if (nmt_hit) begin
          case (cmd)
            CS_START: begin
              r_next.st  = S_OPER;
              r_next.act = 1'b1;
            end
            CS_STOP: begin
              r_next.st  = S_STOP;
              r_next.act = 1'b0;
            end
            CS_PREOP: r_next.st = S_PREOP;
            CS_RST_NODE: begin
              r_next.st       = S_INIT;
              r_next.init_cnt = 4'h0;
              r_next.full     = 1'b1;
            end
            CS_RST_COMM: begin
              r_next.st       = S_INIT;
              r_next.init_cnt = 4'h0;
              r_next.full     = 1'b0;
            end
            default: ;
          endcase
        end
      end
    endcase

    // Service writes are refused outside pre-operational and operational.
    if (wr && svc) begin
      unique case (addr)
        A_GUARD:     r_next.guard   = wdata[15:0];
        A_FACTOR:    r_next.factor  = wdata[7:0];
        A_HB:        r_next.hb      = wdata[15:0];
        A_RPDO_ID:   r_next.rpdo_id = wdata[10:0];
        A_TPDO_ID:   r_next.tpdo_id = wdata[10:0];
        A_MAP_CNT: begin
          r_next.rx_cnt = wdata[3:0];
          r_next.tx_cnt = wdata[7:4];
        end
        A_ERR:       r_next.err     = r_reg.err & ~wdata[7:0];
        A_ERR_VAL:   r_next.err_val = wdata[15:0];
        A_RX_MAP:    r_next.rx_map  = wdata;
        A_TX_MAP_LO: r_next.tx_map[31:0]  = wdata;
        A_TX_MAP_HI: r_next.tx_map[63:32] = wdata;
        default: ;
      endcase
    end

    if (rd) begin
      unique case (addr)
        A_STATE:     r_next.rdata = {24'h000000, node_state};
        A_GUARD:     r_next.rdata = {16'h0000, r_reg.guard};
        A_FACTOR:    r_next.rdata = {24'h000000, r_reg.factor};
        A_HB:        r_next.rdata = {16'h0000, r_reg.hb};
        A_RPDO_ID:   r_next.rdata = {21'h0, r_reg.rpdo_id};
        A_TPDO_ID:   r_next.rdata = {21'h0, r_reg.tpdo_id};
        A_MAP_CNT:   r_next.rdata = {24'h000000, r_reg.tx_cnt,
                                     r_reg.rx_cnt};
        A_ERR:       r_next.rdata = {24'h000000, r_reg.err};
        A_ERR_LOG:   r_next.rdata = r_reg.err_log;
        A_ERR_VAL:   r_next.rdata = {16'h0000, r_reg.err_val};
        A_RX_MAP:    r_next.rdata = r_reg.rx_map;
        A_TX_MAP_LO: r_next.rdata = r_reg.tx_map[31:0];
        A_TX_MAP_HI: r_next.rdata = r_reg.tx_map[63:32];
        default:     r_next.rdata = 32'h0000_0000;
      endcase
    end

    // Placed after the write so a new error beats a clear.
    if (err_event && r_reg.st != S_INIT) begin
      r_next.err     = r_next.err | err_class;
      r_next.err_log = {r_reg.err_log[23:0], err_code};
      if (svc) begin
        r_next.emcy_v    = 1'b1;
        r_next.emcy_code = err_code;
      end
    end

    // Received bytes go to objects in mapping-table order.
    if (rx_valid && !nmt_frame && r_reg.st == S_OPER
        && rx_id == r_reg.rpdo_id) begin
      for (int i = 0; i < 8; i++) begin
        code = r_reg.rx_map[4*i +: 4];
        b    = rx_data[8*i +: 8];
        if (4'(i) < r_reg.rx_cnt && 4'(i) < rx_len) begin
          if (code == 4'h1) begin
            r_next.dout[7:0] = b;
          end else if (code == 4'h2) begin
            r_next.dout[15:8] = b;
          end else if (code >= 4'h3 && code <= 4'hA) begin
            sidx = {1'b0, code - 4'h3};
            r_next.pwm[8*sidx +: 8] = b;
          end
        end
      end
    end

    // Transmit only while operational; length clamps at eight bytes.
    if (tx_trigger && r_reg.st == S_OPER) begin
      len = (r_reg.tx_cnt > MAX_PDO_LEN) ? MAX_PDO_LEN : r_reg.tx_cnt;
      r_next.tx_v   = 1'b1;
      r_next.tx_id  = r_reg.tpdo_id;
      r_next.tx_len = len;
      for (int i = 0; i < 8; i++) begin
        sel = r_reg.tx_map[8*i +: 8];
        b   = 8'h00;
        if (sel >= 8'h01 && sel <= 8'h03) begin
          sidx = 5'(sel - 8'h01);
          b    = digital_input[8*sidx +: 8];
        end else if (sel >= 8'h04 && sel <= 8'h13) begin
          sidx = 5'(sel - 8'h04);
          b    = analog_input[8*sidx +: 8];
        end
        r_next.tx_data[8*i +: 8] = (4'(i) < len) ? b : 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_reg      <= '0;
      r_reg.st   <= S_INIT;
      r_reg.full <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (r_reg.st)
      S_INIT:  node_state = ST_BOOT;
      S_PREOP: node_state = ST_PREOP;
      S_OPER:  node_state = ST_OPER;
      S_STOP:  node_state = ST_STOP;
      default: node_state = ST_BOOT;
    endcase
  end

  assign pdo_enable   = r_reg.st == S_OPER;
  assign sdo_enable   = r_reg.st == S_PREOP || r_reg.st == S_OPER;
  assign sync_enable  = sdo_enable;
  assign emcy_enable  = sdo_enable;
  // Monitoring survives stopped so a master can still see the node.
  assign guard_enable = r_reg.st != S_INIT;
  assign hb_enable    = r_reg.st != S_INIT && r_reg.hb != 16'h0000;
  assign life_time    = (r_reg.guard != 16'h0000 && r_reg.factor != 8'h00)
                        ? 24'(r_reg.guard) * 24'(r_reg.factor)
                        : 24'h000000;
  // Error value replaces the digital outputs, and pulse outputs go to zero, whenever they are not active.
  assign digital_output = r_reg.act ? r_reg.dout : r_reg.err_val;
  assign pulse_output   = r_reg.act ? r_reg.pwm : 64'h0000_0000_0000_0000;
  assign rdata        = r_reg.rdata;
  assign tx_valid     = r_reg.tx_v;
  assign tx_id        = r_reg.tx_id;
  assign tx_len       = r_reg.tx_len;
  assign tx_data      = r_reg.tx_data;
  assign emcy_valid   = r_reg.emcy_v;
  assign emcy_code    = r_reg.emcy_code;
  assign bootup_valid = r_reg.boot_v;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_start;
    nmt_hit && cmd == CS_START |=> node_state == ST_OPER && pdo_enable;
  endproperty
  a_start: assert property (p_start) else $error("start failed");

  property p_stop;
    nmt_hit && cmd == CS_STOP |=> node_state == ST_STOP && !pdo_enable
      && !sdo_enable && digital_output == r_reg.err_val;
  endproperty
  a_stop: assert property (p_stop) else $error("stop failed");

  property p_preop;
    nmt_hit && cmd == CS_PREOP |=> node_state == ST_PREOP && sdo_enable
      && !pdo_enable;
  endproperty
  a_preop: assert property (p_preop) else $error("preop failed");

  property p_rst_node;
    nmt_hit && cmd == CS_RST_NODE |=> node_state == ST_BOOT
      ##4 node_state == ST_PREOP && bootup_valid;
  endproperty
  a_rst_node: assert property (p_rst_node) else $error("reset bad");

  property p_stay;
    node_state == ST_STOP && !nmt_hit |=> node_state == ST_STOP;
  endproperty
  a_stay: assert property (p_stay) else $error("left stopped");

  property p_ignore;
    nmt_frame && !addr_ok && r_reg.st != S_INIT |=> $stable(node_state);
  endproperty
  a_ignore: assert property (p_ignore) else $error("not ignored");

  property p_tx;
    tx_valid |-> tx_len <= MAX_PDO_LEN && $past(pdo_enable);
  endproperty
  a_tx: assert property (p_tx) else $error("bad transmit");

  property p_emcy;
    emcy_valid |-> $past(r_reg.st) != S_STOP && $past(err_event);
  endproperty
  a_emcy: assert property (p_emcy) else $error("emcy in stop");

  property p_boot;
    $rose(r_reg.st == S_INIT) |-> ##[1:8] node_state == ST_PREOP;
  endproperty
  a_boot: assert property (p_boot) else $error("no preop");

endmodule

// file: tb/nsc_master_model.sv
// Purpose: Network master model that sends frames to the node.
// Assumes: Frames are launched just after a rising edge of mclk.
// Notes:   Between frames the identifier and data lines carry the inverse of the last frame.
`timescale 1ns/1ps

module nsc_master_model
  import nsc_pkg::*;
(
  input  wire logic        mclk,
  output logic             rx_valid,
  output logic [10:0]      rx_id,
  output logic [3:0]       rx_len,
  output logic [63:0]      rx_data
);
  initial begin
    rx_valid = 1'h0;
    rx_id    = 11'h7FF;
    rx_len   = 4'h0;
    rx_data  = 64'h0;
  end

  // A frame stands for exactly one edge; the lines are then scrambled so
  // that a stale value can never pass for a fresh frame.
  task automatic send(input logic [10:0] id, input logic [3:0] len,
                      input logic [63:0] data);
    @(posedge mclk);
    rx_valid <= 1'h1;
    rx_id    <= id;
    rx_len   <= len;
    rx_data  <= data;
    @(posedge mclk);
    rx_valid <= 1'h0;
    rx_id    <= ~id;
    rx_data  <= ~data;
  endtask

  // State commands: identifier zero, two bytes, command then target.
  task automatic command(input logic [7:0] cs, input logic [7:0] target);
    send(NMT_ID, NMT_LEN, {48'h0, target, cs});
  endtask
endmodule

// file: tb/nsc_top_test.sv
// Purpose: Self-checking bench for the node state controller.
// Assumes: Node address strap fixed; master model drives the frames.
// Notes:   Each scenario is one task that drives and judges.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  err_total++; $display("BAD %s exp %h got %h", nm, exp, got); end end

module nsc_top_test;
  import nsc_pkg::*;
  localparam logic [6:0] NODE = 7'h05;
  logic        mclk, resetn, tx_trigger, err_event, wr, rd, rx_valid;
  logic        tx_valid, emcy_valid, bootup_valid, pdo_enable, sdo_enable;
  logic        sync_enable, emcy_enable, guard_enable, hb_enable;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  rx_len, tx_len, addr;
  logic [63:0] rx_data, tx_data, pulse_output;
  logic [23:0] digital_input, life_time;
  logic [127:0] analog_input;
  logic [7:0]  err_class, err_code, emcy_code, node_state;
  logic [31:0] wdata, rdata;
  logic [15:0] digital_output;
  int          err_total, comparisons;

  nsc_top u_nsc_top (.mclk, .resetn, .target_node_address(NODE),
    .rx_valid, .rx_id, .rx_len, .rx_data, .digital_input, .analog_input,
    .tx_trigger, .err_event, .err_class, .err_code, .addr, .wdata, .wr,
    .rd, .rdata, .tx_valid, .tx_id, .tx_len, .tx_data, .emcy_valid,
    .emcy_code, .bootup_valid, .digital_output, .pulse_output, .pdo_enable,
    .sdo_enable, .sync_enable, .emcy_enable, .guard_enable, .hb_enable,
    .life_time, .node_state);

  nsc_master_model u_nsc_master_model (.mclk, .rx_valid, .rx_id, .rx_len,
    .rx_data);

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge mclk);
    wr    <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge mclk);
    rd   <= 1'h0;
    #1 d = rdata;
  endtask

  task automatic pulse(input bit tx);
    @(posedge mclk);
    if (tx) tx_trigger <= 1'h1;
    else err_event <= 1'h1;
    @(posedge mclk);
    tx_trigger <= 1'h0;
    err_event  <= 1'h0;
    #1;
  endtask

  task automatic cmd(input logic [7:0] cs, input logic [7:0] tg);
    u_nsc_master_model.command(cs, tg);
    #1;
  endtask

  task automatic wait_preop(input string nm);
    int n;
    n = 0;
    while (node_state !== ST_PREOP && n < 12) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(nm, ST_PREOP, node_state)
    `CHK("bootup", 1'h1, bootup_valid)
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    logic [31:0] d;
    reg_rd(A_STATE, d);
    `CHK("state reg", {24'h0, ST_PREOP}, d)
    `CHK("pdo preop", 1'h0, pdo_enable)
    `CHK("sdo preop", 1'h1, sdo_enable)
    reg_wr(A_GUARD, 32'h0000_0003);
    reg_wr(A_FACTOR, 32'h0000_0005);
    reg_rd(4'hF, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("life", 24'h00000F, life_time)
    reg_wr(A_FACTOR, 32'h0);
    reg_rd(A_FACTOR, d);
    `CHK("life zero", 24'h0, life_time)
    pulse(1);
    `CHK("tx preop", 1'h0, tx_valid)
    $display("test cfg done");
  endtask

  task automatic t_start();
    cmd(CS_START, BROADCAST);
    `CHK("oper", ST_OPER, node_state)
    `CHK("pdo oper", 1'h1, pdo_enable)
    `CHK("sdo oper", 1'h1, sdo_enable)
    u_nsc_master_model.send(RPDO_BASE + {4'h0, NODE}, 4'h2, 64'hBBAA);
    #1;
    `CHK("rpdo out", 16'hBBAA, digital_output)
    pulse(1);
    `CHK("tpdo", 1'h1, tx_valid)
    `CHK("tpdo id", TPDO_BASE + {4'h0, NODE}, tx_id)
    `CHK("tpdo len", 4'h3, tx_len)
    `CHK("tpdo data", 64'h0000_0000_0033_2211, tx_data)
    // Long count with analog bytes mapped checks the eight-byte ceiling.
    reg_wr(A_MAP_CNT, 32'h0000_00F2);
    reg_wr(A_TX_MAP_LO, 32'h0504_0201);
    reg_wr(A_HB, 32'h0000_0064);
    reg_wr(A_ERR_VAL, 32'h0000_00F0);
    pulse(1);
    `CHK("tpdo max", 4'h8, tx_len)
    `CHK("tpdo ana", 64'h0000_0000_C3A0_2211, tx_data)
    // Map both received bytes onto the first pulse word, then restore.
    reg_wr(A_RX_MAP, 32'h0000_0043);
    u_nsc_master_model.send(RPDO_BASE + {4'h0, NODE}, 4'h2, 64'h7788);
    #1;
    `CHK("rpdo pwm", 64'h0000_0000_0000_7788, pulse_output)
    `CHK("rpdo keep", 16'hBBAA, digital_output)
    reg_wr(A_RX_MAP, RX_MAP_RST);
    $display("test start done");
  endtask

  task automatic t_filter();
    cmd(CS_STOP, 8'h06);
    `CHK("other node", ST_OPER, node_state)
    cmd(8'h03, BROADCAST);
    `CHK("bad cmd", ST_OPER, node_state)
    $display("test filter done");
  endtask

  task automatic t_stop();
    logic [31:0] d;
    cmd(CS_STOP, {1'h0, NODE});
    `CHK("stopped", ST_STOP, node_state)
    `CHK("err out", 16'h00F0, digital_output)
    `CHK("pwm stop", 64'h0, pulse_output)
    `CHK("pdo stop", 4'h0, {pdo_enable, sdo_enable, sync_enable,
                             emcy_enable})
    `CHK("guard stop", 2'h3, {guard_enable, hb_enable})
    u_nsc_master_model.send(RPDO_BASE + {4'h0, NODE}, 4'h2, 64'h1234);
    #1;
    `CHK("rpdo stop", 16'h00F0, digital_output)
    `CHK("still stop", ST_STOP, node_state)
    pulse(0);
    `CHK("emcy stop", 1'h0, emcy_valid)
    reg_wr(A_GUARD, 32'h0000_0007);
    reg_rd(A_GUARD, d);
    `CHK("sdo stop", 32'h0000_0003, d)
    $display("test stop done");
  endtask

  task automatic t_preop();
    logic [31:0] d;
    cmd(CS_PREOP, BROADCAST);
    `CHK("preop", ST_PREOP, node_state)
    `CHK("pdo/sdo", 2'h1, {pdo_enable, sdo_enable})
    pulse(0);
    `CHK("emcy", 1'h1, emcy_valid)
    `CHK("emcy code", 8'h5A, emcy_code)
    reg_rd(A_ERR, d);
    `CHK("err reg", 8'h04, d[7:0])
    reg_rd(A_ERR_LOG, d);
    `CHK("err log", 32'h0000_5A5A, d)
    // Frames sent while stopped or pre-operational must not reach dout.
    u_nsc_master_model.send(RPDO_BASE + {4'h0, NODE}, 4'h2, 64'h5555);
    cmd(CS_START, {1'h0, NODE});
    `CHK("rpdo held", 16'hBBAA, digital_output)
    $display("test preop done");
  endtask

  task automatic t_resets();
    logic [31:0] d;
    cmd(CS_RST_COMM, {1'h0, NODE});
    `CHK("comm boot", ST_BOOT, node_state)
    wait_preop("comm preop");
    reg_rd(A_GUARD, d);
    `CHK("comm guard", 32'h0, d)
    reg_rd(A_ERR, d);
    `CHK("comm err", 8'h04, d[7:0])
    `CHK("comm out", 16'hBBAA, digital_output)
    cmd(CS_RST_NODE, BROADCAST);
    `CHK("node boot", ST_BOOT, node_state)
    wait_preop("node preop");
    reg_rd(A_ERR, d);
    `CHK("node err", 8'h00, d[7:0])
    `CHK("node out", 16'h0, digital_output)
    `CHK("node pwm", 64'h0, pulse_output)
    $display("test resets done");
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatched %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // The tests need well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge mclk);
    err_total++;
    $display("BAD watchdog exp done got hang");
    finish_test();
  end

  initial begin
    resetn        = 1'h0;
    tx_trigger    = 1'h0;
    err_event     = 1'h0;
    wr            = 1'h0;
    rd            = 1'h0;
    addr          = 4'h0;
    wdata         = 32'h0;
    digital_input = 24'h332211;
    analog_input  = {112'h0, 16'hC3A0};
    err_class     = 8'h04;
    err_code      = 8'h5A;
    err_total     = 0;
    comparisons   = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'h1;
    #1;
    `CHK("boot", ST_BOOT, node_state)
    wait_preop("power on");
    t_cfg();
    t_start();
    t_filter();
    t_stop();
    t_preop();
    t_resets();
    finish_test();
  end
endmodule
